// ===== inc/lbgr_pkg.sv
// Shared constants and types for the local bus grant relay
package lbgr_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [23:0] LBGR_CTRL_ADDR    = 24'hCA0008;  // ext_dma_line_control
	localparam logic [23:0] LBGR_STAT_ADDR    = 24'hCA000A;  // ext_line_status
	localparam logic [23:0] LBGR_SOFT_RST_ADDR = 24'hF00000; // Backplane ROM soft reset
	localparam logic [15:0] LBGR_CTRL_RESET   = 16'h0000;    // All lines in DMA use

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int LBGR_ACK_MODE_LSB = 2;  // Grant-acknowledge mode, D3:D2
	localparam int LBGR_REQ_MODE_LSB = 4;  // Request mode, D5:D4
	localparam int LBGR_GNT_MODE_LSB = 6;  // Grant mode, D7:D6
	localparam int LBGR_GPO_REQ_BIT  = 8;  // Output level of request line as GPIO
	localparam int LBGR_GPO_GNT_BIT  = 9;  // Output level of grant line as GPIO
	localparam int LBGR_GPO_ACK_BIT  = 10; // Output level of acknowledge line as GPIO
	localparam int LBGR_STAT_REQ_BIT = 0;  // Live request level
	localparam int LBGR_STAT_GNT_BIT = 1;  // Live grant level
	localparam int LBGR_STAT_ACK_BIT = 2;  // Live acknowledge level

	// ----------------------------------------------------------------
	// Address decode regions (top nibble of the local address)
	// ----------------------------------------------------------------
	localparam logic [3:0] LBGR_DEC_REQ = 4'h8;
	localparam logic [3:0] LBGR_DEC_GNT = 4'h9;
	localparam logic [3:0] LBGR_DEC_ACK = 4'hA;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int LBGR_SYS_CLK_HZ   = 20000000;
	localparam int LBGR_SLOW_CLK_HZ  = 10000000;
	localparam int LBGR_SLOW_HALF    = LBGR_SYS_CLK_HZ / (2 * LBGR_SLOW_CLK_HZ);
	localparam int LBGR_HW_RST_TICKS = 4;    // Slow-clock ticks of hardware reset delay
	localparam int LBGR_SYS_PERIOD_NS = 1000000000 / LBGR_SYS_CLK_HZ;
	localparam int LBGR_SOFT_RST_NS  = 800;  // Soft reset pulse width
	localparam int LBGR_SOFT_RST_CYC =
		(LBGR_SOFT_RST_NS + LBGR_SYS_PERIOD_NS - 1) / LBGR_SYS_PERIOD_NS;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		LBGR_MODE_DMA    = 2'h0,
		LBGR_MODE_GPIN   = 2'h1,
		LBGR_MODE_GPOUT  = 2'h2,
		LBGR_MODE_DECODE = 2'h3
	} lbgr_mode_t;

	// Local processor reset sequencer, Gray along run -> hold -> soft
	typedef enum logic [1:0] {
		LBGR_RS_RUN  = 2'h0,
		LBGR_RS_HW   = 2'h1,
		LBGR_RS_SOFT = 2'h3
	} lbgr_rst_t;

	// The three external control lines, one bit each
	typedef struct packed {
		logic ack;
		logic grant;
		logic req;
	} lbgr_lines_t;

endpackage : lbgr_pkg

// ===== verilog/lbgr_slow_reset.sv
// Slow local clock generator and delayed hardware reset shifter
`timescale 1ns/10ps
`default_nettype none

module lbgr_slow_reset
	import lbgr_pkg::*;
#(
	parameter int TICKS = LBGR_HW_RST_TICKS // Depth of the reset delay line
) (
	input  wire logic sys_clk,
	input  wire logic rstn,
	input  wire logic ce,
	input  wire logic backplane_reset_n, // Backplane hardware reset, low active
	output logic      local_slow_clock,  // Symmetrical half-rate clock
	output logic      hw_reset_dly_n     // Hardware reset after the delay line
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic             slow;  // Slow clock level
		logic [TICKS-1:0] shift; // Delay line, bit 0 entry
	} lbgr_sr_state_t;

	lbgr_sr_state_t st_reg;  // Registered state
	lbgr_sr_state_t st_next; // Next state

	// Next state: the clock toggles every enabled cycle, shifting on its rise
	always_comb begin
		st_next      = st_reg;
		st_next.slow = ~st_reg.slow;
		if (!st_reg.slow) begin
			// Shift on the rising tick only, so the delay counts slow clocks
			st_next.shift = {st_reg.shift[TICKS-2:0], backplane_reset_n};
		end
	end

	// Register with clock enable; the line starts out of reset
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			st_reg <= '{slow: 1'b0, shift: {TICKS{1'b1}}};
		end else if (ce) begin
			st_reg <= st_next;
		end
	end

	assign local_slow_clock = st_reg.slow;
	assign hw_reset_dly_n   = st_reg.shift[TICKS-1];

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic [4:0] low_cnt; // Enabled cycles the backplane reset has been low

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			low_cnt <= 5'h00;
		end else if (ce) begin
			low_cnt <= backplane_reset_n ? 5'h00 : (low_cnt == 5'h1F ? low_cnt : low_cnt + 5'h01);
		end
	end

	property p_hw_delay;
		@(posedge sys_clk) disable iff (!rstn)
		$fell(hw_reset_dly_n) |-> (low_cnt >= 5'h06);
	endproperty
	a_hw_delay: assert property (p_hw_delay) else $error("reset delay too short");

	property p_slow_toggle;
		@(posedge sys_clk) disable iff (!rstn)
		ce |=> (local_slow_clock != $past(local_slow_clock));
	endproperty
	a_slow_toggle: assert property (p_slow_toggle) else $error("slow clock stuck");

endmodule : lbgr_slow_reset

`default_nettype wire

// ===== verilog/lbgr_relay.sv
// Local bus grant relay: external DMA line relay, line modes and local reset
`timescale 1ns/10ps
`default_nettype none

module lbgr_relay
	import lbgr_pkg::*;
(
	input  wire logic         sys_clk,
	input  wire logic         rstn,
	input  wire logic         ce,
	// Local processor register port
	input  wire logic         lb_sel,           // Register access strobe
	input  wire logic         lb_write,         // High for write
	input  wire logic [23:0]  lb_addr,          // Local address
	input  wire logic [15:0]  lb_wdata,         // Write data
	output logic [15:0]       lb_rdata,         // Read data
	output logic              lb_ack,           // Access done
	// External control lines as three-signal pads
	input  wire lbgr_lines_t  ext_lines_in,     // Pad levels, low active in DMA
	output lbgr_lines_t       ext_lines_out,    // Pad drive levels
	output lbgr_lines_t       ext_lines_oe,     // High while driving
	// Local processor arbitration
	output logic              cpu_bus_request_n,
	input  wire logic         cpu_bus_grant_n,
	output logic              cpu_grant_ack_n,
	// Backplane side
	input  wire logic         backplane_reset_n, // Backplane hardware reset
	input  wire logic         bp_sel,            // Inbound backplane access active
	input  wire logic         bp_read,           // Inbound access is a read
	input  wire logic [23:0]  bp_addr,           // Inbound address
	input  wire logic         card_out_req,      // Card wants a backplane cycle
	input  wire logic         card_out_busy,     // Card-to-backplane cycle running
	output logic              outbound_grant,    // Outbound cycle may start
	output logic              local_bus_error_n, // Bus error to local owner
	// Local reset and clock
	output logic              local_cpu_reset_n,
	output logic              local_slow_clock
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [15:0] ctrl;     // ext_dma_line_control
		logic [15:0] rdata;    // Read data
		logic        ack;      // Access acknowledge
		logic        br_n;     // Processor request
		logic        back_n;   // Processor acknowledge
		lbgr_lines_t pout;     // Pad drive
		lbgr_lines_t poe;      // Pad enable
		lbgr_rst_t   rst;      // Reset sequencer
		logic [4:0]  soft_cnt; // Soft reset width counter
		logic        rst_n;    // Processor reset
		logic        berr_n;   // Bus error
		logic        out_go;   // Outbound grant
	} lbgr_state_t;

	lbgr_state_t st_reg;  // Registered state
	lbgr_state_t st_next; // Next state
	logic        hw_dly_n; // Delayed hardware reset

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Mode field of one line
	function automatic lbgr_mode_t mode_of(input logic [15:0] c, input int lsb);
		mode_of = lbgr_mode_t'(c[lsb +: 2]);
	endfunction : mode_of

	// Pad drive for one line; returns {oe, out}
	function automatic logic [1:0] pad_of(input lbgr_mode_t m, input logic gpo,
		input logic hit, input logic dma_is_out, input logic dma_val);
		case (m)
			LBGR_MODE_DMA:    pad_of = {dma_is_out, dma_is_out ? dma_val : 1'b1};
			LBGR_MODE_GPIN:   pad_of = 2'b01;
			LBGR_MODE_GPOUT:  pad_of = {1'b1, gpo};
			default:          pad_of = {1'b1, ~hit}; // Decode is low active
		endcase
	endfunction : pad_of

	lbgr_mode_t m_req; // Request line mode
	lbgr_mode_t m_gnt; // Grant line mode
	lbgr_mode_t m_ack; // Acknowledge line mode
	logic [2:0] hit;   // Decode region hits: ack, grant, req
	logic       soft_hit; // Soft reset ROM read

	assign m_ack    = mode_of(st_reg.ctrl, LBGR_ACK_MODE_LSB);
	assign m_req    = mode_of(st_reg.ctrl, LBGR_REQ_MODE_LSB);
	assign m_gnt    = mode_of(st_reg.ctrl, LBGR_GNT_MODE_LSB);
	assign hit      = {3{lb_sel}} & {lb_addr[23:20] == LBGR_DEC_ACK,
	                                 lb_addr[23:20] == LBGR_DEC_GNT,
	                                 lb_addr[23:20] == LBGR_DEC_REQ};
	assign soft_hit = bp_sel && bp_read && (bp_addr == LBGR_SOFT_RST_ADDR);

	// ----------------------------------------------------------------
	// Slow clock and delayed hardware reset
	// ----------------------------------------------------------------
	lbgr_slow_reset #(
		.TICKS             (LBGR_HW_RST_TICKS)
	) u_slow_reset (
		.sys_clk           (sys_clk),
		.rstn              (rstn),
		.ce                (ce),
		.backplane_reset_n (backplane_reset_n),
		.local_slow_clock  (local_slow_clock),
		.hw_reset_dly_n    (hw_dly_n)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [1:0] pr;
		logic [1:0] pg;
		logic [1:0] pa;
		st_next = st_reg;
		pr      = 2'b00;
		pg      = 2'b00;
		pa      = 2'b00;

		// Register port: acknowledge follows the strobe by one cycle
		st_next.ack = lb_sel;
		if (lb_sel && lb_addr == LBGR_CTRL_ADDR) begin
			// Control word
			if (lb_write) begin
				st_next.ctrl = lb_wdata;
			end
			st_next.rdata = st_reg.ctrl;
		end else if (lb_sel && lb_addr == LBGR_STAT_ADDR) begin
			// Live levels whatever the mode; writes ignored
			st_next.rdata = 16'h0000;
			st_next.rdata[LBGR_STAT_ACK_BIT] = ext_lines_in.ack;
			st_next.rdata[LBGR_STAT_GNT_BIT] = ext_lines_in.grant;
			st_next.rdata[LBGR_STAT_REQ_BIT] = ext_lines_in.req;
		end else if (lb_sel) begin
			// Unmapped address reads as zero
			st_next.rdata = 16'h0000;
		end

		// Relay through lines in DMA use only
		st_next.br_n   = (m_req == LBGR_MODE_DMA) ? ext_lines_in.req : 1'b1;
		st_next.back_n = (m_ack == LBGR_MODE_DMA) ? ext_lines_in.ack : 1'b1;

		// Pad drive per mode; grant is the only DMA output
		pr = pad_of(m_req, st_reg.ctrl[LBGR_GPO_REQ_BIT], hit[0], 1'b0, 1'b1);
		pg = pad_of(m_gnt, st_reg.ctrl[LBGR_GPO_GNT_BIT], hit[1], 1'b1,
			cpu_bus_grant_n);
		pa = pad_of(m_ack, st_reg.ctrl[LBGR_GPO_ACK_BIT], hit[2], 1'b0, 1'b1);
		st_next.poe  = '{ack: pa[1], grant: pg[1], req: pr[1]};
		st_next.pout = '{ack: pa[0], grant: pg[0], req: pr[0]};

		// Inbound access owns the local bus; clash errors the owner
		st_next.out_go = card_out_req && !bp_sel;
		st_next.berr_n = !(bp_sel && card_out_busy);

		// Reset sequencer
		case (st_reg.rst)
			LBGR_RS_RUN: begin
				if (soft_hit) begin
					// No delay line here, unlike the hardware path
					st_next.rst      = LBGR_RS_SOFT;
					st_next.soft_cnt = 5'(LBGR_SOFT_RST_CYC - 1);
				end else if (!hw_dly_n) begin
					st_next.rst = LBGR_RS_HW;
				end
			end
			LBGR_RS_HW: begin
				// Release follows the delayed line as well
				if (hw_dly_n && soft_hit) begin
					// A soft read on the release edge starts a fresh pulse
					st_next.rst      = LBGR_RS_SOFT;
					st_next.soft_cnt = 5'(LBGR_SOFT_RST_CYC - 1);
				end else if (hw_dly_n) begin
					st_next.rst = LBGR_RS_RUN;
				end
			end
			LBGR_RS_SOFT: begin
				if (soft_hit) begin
					// A repeated soft read stretches the pulse, never drops it
					st_next.soft_cnt = 5'(LBGR_SOFT_RST_CYC - 1);
				end else if (st_reg.soft_cnt != 5'h00) begin
					st_next.soft_cnt = st_reg.soft_cnt - 5'h01;
				end else begin
					st_next.rst = hw_dly_n ? LBGR_RS_RUN : LBGR_RS_HW;
				end
			end
			default: begin
				st_next.rst = LBGR_RS_RUN;
			end
		endcase
		st_next.rst_n = (st_next.rst == LBGR_RS_RUN);
	end

	// Register all state; low clock enable freezes it
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			st_reg <= '{ctrl: LBGR_CTRL_RESET, rdata: 16'h0000, ack: 1'b0,
				br_n: 1'b1, back_n: 1'b1, pout: 3'h7, poe: 3'h0,
				rst: LBGR_RS_RUN, soft_cnt: 5'h00, rst_n: 1'b0,
				berr_n: 1'b1, out_go: 1'b0};
		end else if (ce) begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign lb_rdata          = st_reg.rdata;
	assign lb_ack            = st_reg.ack;
	assign ext_lines_out     = st_reg.pout;
	assign ext_lines_oe      = st_reg.poe;
	assign cpu_bus_request_n = st_reg.br_n;
	assign cpu_grant_ack_n   = st_reg.back_n;
	assign outbound_grant    = st_reg.out_go;
	assign local_bus_error_n = st_reg.berr_n;
	assign local_cpu_reset_n = st_reg.rst_n;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_dma_dirs;
		@(posedge sys_clk) disable iff (!rstn)
		ce && m_req == LBGR_MODE_DMA && m_ack == LBGR_MODE_DMA && m_gnt == LBGR_MODE_DMA
			|=> !ext_lines_oe.req && !ext_lines_oe.ack && ext_lines_oe.grant;
	endproperty
	a_dma_dirs: assert property (p_dma_dirs) else $error("DMA pad direction wrong");

	property p_req_fwd;
		@(posedge sys_clk) disable iff (!rstn)
		ce && m_req == LBGR_MODE_DMA && !ext_lines_in.req |=> !cpu_bus_request_n;
	endproperty
	a_req_fwd: assert property (p_req_fwd) else $error("request not forwarded");

	property p_gnt_pass;
		@(posedge sys_clk) disable iff (!rstn)
		ce && m_gnt == LBGR_MODE_DMA |=> ext_lines_out.grant == $past(cpu_bus_grant_n);
	endproperty
	a_gnt_pass: assert property (p_gnt_pass) else $error("grant not passed");

	property p_ack_copy;
		@(posedge sys_clk) disable iff (!rstn)
		ce && m_ack == LBGR_MODE_DMA |=> cpu_grant_ack_n == $past(ext_lines_in.ack);
	endproperty
	a_ack_copy: assert property (p_ack_copy) else $error("acknowledge not copied");

	property p_ack_decode;
		@(posedge sys_clk) disable iff (!rstn)
		ce && m_ack == LBGR_MODE_DECODE && hit[2] |=> ext_lines_oe.ack && !ext_lines_out.ack;
	endproperty
	a_ack_decode: assert property (p_ack_decode) else $error("decode not driven");

	property p_gnt_gpin;
		@(posedge sys_clk) disable iff (!rstn)
		ce && m_gnt == LBGR_MODE_GPIN |=> !ext_lines_oe.grant;
	endproperty
	a_gnt_gpin: assert property (p_gnt_gpin) else $error("grant driven as input");

	property p_req_gpout;
		@(posedge sys_clk) disable iff (!rstn)
		ce && m_req == LBGR_MODE_GPOUT
			|=> ext_lines_oe.req && ext_lines_out.req == $past(st_reg.ctrl[LBGR_GPO_REQ_BIT]);
	endproperty
	a_req_gpout: assert property (p_req_gpout) else $error("request GPIO wrong");

	property p_status;
		@(posedge sys_clk) disable iff (!rstn)
		ce && lb_sel && !lb_write && lb_addr == LBGR_STAT_ADDR
			|=> lb_rdata[2:0] == $past({ext_lines_in.ack, ext_lines_in.grant, ext_lines_in.req});
	endproperty
	a_status: assert property (p_status) else $error("status levels wrong");

	property p_hw_rst;
		@(posedge sys_clk) disable iff (!rstn)
		ce && !hw_dly_n |=> !local_cpu_reset_n;
	endproperty
	a_hw_rst: assert property (p_hw_rst) else $error("hardware reset missed");

	property p_soft_rst;
		@(posedge sys_clk) disable iff (!rstn)
		ce && soft_hit |=> !local_cpu_reset_n;
	endproperty
	a_soft_rst: assert property (p_soft_rst) else $error("soft reset late");

	property p_inbound_first;
		@(posedge sys_clk) disable iff (!rstn)
		ce && bp_sel |=> !outbound_grant;
	endproperty
	a_inbound_first: assert property (p_inbound_first) else $error("outbound beat inbound");

	property p_berr;
		@(posedge sys_clk) disable iff (!rstn)
		ce && bp_sel && card_out_busy |=> !local_bus_error_n;
	endproperty
	a_berr: assert property (p_berr) else $error("conflict without bus error");

	property p_no_relay;
		@(posedge sys_clk) disable iff (!rstn)
		ce && m_req != LBGR_MODE_DMA && m_ack != LBGR_MODE_DMA
			|=> cpu_bus_request_n && cpu_grant_ack_n;
	endproperty
	a_no_relay: assert property (p_no_relay) else $error("relay through non-DMA line");

endmodule : lbgr_relay

`default_nettype wire

// ===== tb/lbgr_far_side.sv
// Behavioural model of the external bus master and the local processor
`timescale 1ns/10ps
`default_nettype none

module lbgr_far_side
	import lbgr_pkg::*;
#(
	parameter int HOLD = 20 // Master tenure in cycles, 1 us at 20 MHz
) (
	input  wire logic       sys_clk,
	input  wire logic       rstn,
	input  wire logic       want_bus,          // Bench asks the master to take the bus
	input  wire logic [3:0] grant_delay,       // Processor grant latency
	input  wire logic       cpu_bus_request_n,
	input  wire logic       ext_grant_n,       // Resolved grant pad
	input  wire logic       local_bus_error_n,
	output logic            ext_req_n,         // 1 when released, the pull-up level
	output logic            ext_ack_n,         // 1 when released, the pull-up level
	output logic            cpu_bus_grant_n
);
	logic [3:0] gnt_cnt;  // Cycles the request has waited
	int         hold_cnt; // Cycles of tenure so far
	logic       done;     // Tenure over until want_bus falls

	// ------------
	// Processor: grants after a latency, withdraws when the request goes
	// ------------
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			gnt_cnt <= 4'h0;
			cpu_bus_grant_n <= 1'b1;
		end else if (cpu_bus_request_n) begin
			gnt_cnt <= 4'h0;
			cpu_bus_grant_n <= 1'b1;
		end else if (gnt_cnt >= grant_delay) begin
			cpu_bus_grant_n <= 1'b0;
		end else begin
			gnt_cnt <= gnt_cnt + 4'h1;
		end
	end

	// ------------
	// Master: request, take the bus on grant, leave soon or on a bus error
	// ------------
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ext_req_n <= 1'b1;
			ext_ack_n <= 1'b1;
			hold_cnt <= 0;
			done <= 1'b0;
		end else if (!ext_ack_n) begin
			hold_cnt <= hold_cnt + 1;
			// Short tenure keeps inbound accesses from timing out
			if (hold_cnt >= HOLD || !local_bus_error_n) begin
				ext_ack_n <= 1'b1;
				done <= 1'b1;
			end
		end else if (!ext_req_n && !ext_grant_n) begin
			ext_ack_n <= 1'b0;
			ext_req_n <= 1'b1;
			hold_cnt <= 0;
		end else begin
			ext_req_n <= !(want_bus && !done);
			if (!want_bus) done <= 1'b0;
		end
	end
endmodule : lbgr_far_side
`default_nettype wire

// ===== tb/local_bus_grant_relay_bench.sv
// Self-checking bench for the local bus grant relay
`timescale 1ns/10ps
`default_nettype none

module local_bus_grant_relay_bench;
	import lbgr_pkg::*;

	// ------------
	// Signals
	// ------------
	typedef struct packed {
		logic        wr;    // Write access
		logic [23:0] addr;  // Register address
		logic [15:0] wdata; // Write data
		logic [2:0]  arb;   // bp_sel, card_out_req, card_out_busy
		logic [15:0] rdata; // Expected read data
		logic [1:0]  arbx;  // Expected outbound_grant, local_bus_error_n
	} lbgr_row_t;
	localparam int HW_DLY = 2 * LBGR_HW_RST_TICKS * LBGR_SLOW_HALF;
	logic        sys_clk = 1'b0;
	logic        rstn = 1'b0;
	logic        lb_sel = 1'b0;
	logic        lb_write = 1'b0;
	logic [23:0] lb_addr = 24'h000000;
	logic [15:0] lb_wdata = 16'h0000;
	logic [15:0] lb_rdata;
	logic        lb_ack;
	lbgr_lines_t l_in, l_out, l_oe;  // Pad level, drive, enable
	logic        req_n, gnt_n, ack_n, err_n, ogrant, rst_n, slow;
	logic        bp_rst_n = 1'b1;
	logic        bp_sel = 1'b0;
	logic        bp_read = 1'b0;
	logic [23:0] bp_addr = 24'h000000;
	logic        c_req = 1'b0;
	logic        c_busy = 1'b0;
	logic        want = 1'b0;
	logic        ce = 1'b1;
	logic [3:0]  gdly = 4'h0;
	logic        m_req_n, m_ack_n;   // Master pad drives
	int          num_errors = 0;
	int          tests_run = 0;
	int          n;                  // Cycles of the last wait
	logic [15:0] q;                  // Last read data
	logic [1:0]  mr, mg, ma;         // Modes of request, grant, ack
	logic [1:0]  xr, xg, xa;         // Expected {oe, pad} per line
	lbgr_row_t   rows [8];
	logic [3:0]  dec [3] = '{LBGR_DEC_REQ, LBGR_DEC_GNT, LBGR_DEC_ACK};
	logic [3:0]  dly [2] = '{4'h0, 4'h6}; // Prompt and slow processor

	always #25 sys_clk = ~sys_clk;

	// Pull-ups hold every undriven pad high
	assign l_in.req   = l_oe.req ? l_out.req : m_req_n;
	assign l_in.grant = l_oe.grant ? l_out.grant : 1'b1;
	assign l_in.ack   = l_oe.ack ? l_out.ack : m_ack_n;

	lbgr_relay u_dut (.sys_clk(sys_clk), .rstn(rstn), .ce(ce), .lb_sel(lb_sel),
		.lb_write(lb_write), .lb_addr(lb_addr), .lb_wdata(lb_wdata), .lb_rdata(lb_rdata),
		.lb_ack(lb_ack), .ext_lines_in(l_in), .ext_lines_out(l_out), .ext_lines_oe(l_oe),
		.cpu_bus_request_n(req_n), .cpu_bus_grant_n(gnt_n), .cpu_grant_ack_n(ack_n),
		.backplane_reset_n(bp_rst_n), .bp_sel(bp_sel), .bp_read(bp_read), .bp_addr(bp_addr),
		.card_out_req(c_req), .card_out_busy(c_busy), .outbound_grant(ogrant),
		.local_bus_error_n(err_n), .local_cpu_reset_n(rst_n), .local_slow_clock(slow));
	lbgr_far_side u_far (.sys_clk(sys_clk), .rstn(rstn), .want_bus(want),
		.grant_delay(gdly), .cpu_bus_request_n(req_n), .ext_grant_n(l_in.grant),
		.local_bus_error_n(err_n), .ext_req_n(m_req_n), .ext_ack_n(m_ack_n),
		.cpu_bus_grant_n(gnt_n));

	// ------------
	// Tasks
	// ------------
	task automatic end_of_test();
		if (num_errors == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
		end
	endtask : chk

	// Inputs move 1 ns after the edge, outputs are settled then too
	task automatic tick(input int k);
		repeat (k) @(posedge sys_clk);
		#1;
	endtask : tick

	// Bounded wait for an output level; a timeout ends the run
	task automatic wait_sig(input int which, input logic v, input int bound);
		logic cur;
		n = 0;
		forever begin
			case (which)
				0: cur = req_n;
				1: cur = l_out.grant;
				2: cur = ack_n;
				3: cur = rst_n;
				default: cur = lb_ack;
			endcase
			if (cur === v) return;
			if (n >= bound) begin
				num_errors++;
				$display("[ERR] %0t wait %0d timed out", $time, which);
				end_of_test();
			end
			tick(1);
			n++;
		end
	endtask : wait_sig

	// Strobe held until ack is high at an edge; idle edge first
	task automatic reg_acc(input logic wr, input logic [23:0] a, input logic [15:0] d);
		tick(1);
		lb_sel = 1'b1;
		lb_write = wr;
		lb_addr = a;
		lb_wdata = d;
		tick(1);
		wait_sig(4, 1'b1, 4);
		q = lb_rdata;
		tick(1);
		lb_sel = 1'b0;
	endtask : reg_acc

	// Expected {oe, pad} of a line; g marks the grant line
	function automatic logic [1:0] line_x(input logic [1:0] md, input logic g, input logic gpo);
		case (md)
			2'h0: return {g, 1'b1};
			2'h1: return 2'b01;
			2'h2: return {1'b1, gpo};
			default: return 2'b11;
		endcase
	endfunction : line_x

	// ------------
	// Sequence
	// ------------
	initial begin
		rows[0] = '{1'b0, LBGR_CTRL_ADDR, 16'h0000, 3'h0, LBGR_CTRL_RESET, 2'h1};
		rows[1] = '{1'b1, LBGR_CTRL_ADDR, 16'h0754, 3'h2, 16'h0000, 2'h3};
		rows[2] = '{1'b1, LBGR_STAT_ADDR, 16'h0000, 3'h7, 16'h0000, 2'h0};
		rows[3] = '{1'b0, LBGR_CTRL_ADDR, 16'h0000, 3'h6, 16'h0754, 2'h1};
		rows[4] = '{1'b0, LBGR_STAT_ADDR, 16'h0000, 3'h5, 16'h0007, 2'h0};
		rows[5] = '{1'b0, 24'hCA000C, 16'h0000, 3'h1, 16'h0000, 2'h1};
		rows[6] = '{1'b1, LBGR_CTRL_ADDR, 16'h0000, 3'h3, 16'h0000, 2'h3};
		rows[7] = '{1'b0, LBGR_CTRL_ADDR, 16'h0000, 3'h0, 16'h0000, 2'h1};
		tick(4);
		chk(rst_n, 1'b0, "cpu reset in reset");
		chk({lb_ack, l_oe}, 4'h0, "ack and enables in reset");
		chk({req_n, ack_n, err_n, ogrant, slow}, 5'h1C, "arbitration in reset");
		rstn = 1'b1;
		tick(2);
		chk(l_oe, 3'h2, "DMA enables");
		foreach (rows[i]) begin
			{bp_sel, c_req, c_busy} = rows[i].arb;
			reg_acc(rows[i].wr, rows[i].addr, rows[i].wdata);
			if (!rows[i].wr) chk(q, rows[i].rdata, "read");
			chk({ogrant, err_n}, rows[i].arbx, "arbitration");
		end
		{bp_sel, c_req, c_busy} = 3'h0;
		// Modes rotated per line so a swapped field shows
		for (int m = 0; m < 4; m++) begin
			mr = 2'(m);
			mg = mr + 2'h1;
			ma = mr + 2'h2;
			xr = line_x(mr, 1'b0, 1'b1);
			xg = line_x(mg, 1'b1, 1'b0);
			xa = line_x(ma, 1'b0, 1'b1);
			reg_acc(1'b1, LBGR_CTRL_ADDR, {8'h05, mg, mr, ma, 2'b00});
			reg_acc(1'b0, LBGR_STAT_ADDR, 16'h0000);
			chk(l_oe, {xa[1], xg[1], xr[1]}, "line enables");
			chk(q, {13'h0000, xa[0], xg[0], xr[0]}, "line status");
		end
		reg_acc(1'b1, LBGR_CTRL_ADDR, 16'h00FC);
		foreach (dec[i]) begin
			reg_acc(1'b0, {dec[i], 20'h00000}, 16'h0000);
			chk(l_out, 3'h7 & ~(3'h1 << i), "decode strobe");
		end
		reg_acc(1'b1, LBGR_CTRL_ADDR, 16'h0000);
		foreach (dly[i]) begin
			gdly = dly[i];
			want = 1'b1;
			wait_sig(0, 1'b0, 4);
			wait_sig(1, 1'b0, 12);
			chk(l_oe.grant, 1'b1, "grant driven");
			wait_sig(2, 1'b0, 4);
			want = 1'b0;
			{bp_sel, c_busy} = {2{i == 1}};
			wait_sig(2, 1'b1, 30);
			if (i == 1) chk(16'(n < 8), 16'h0001, "release on bus error");
			{bp_sel, c_busy} = 2'b00;
		end
		reg_acc(1'b1, LBGR_CTRL_ADDR, 16'h0054);
		want = 1'b1;
		tick(8);
		chk({req_n, ack_n}, 2'h3, "no relay off DMA");
		reg_acc(1'b0, LBGR_STAT_ADDR, 16'h0000);
		chk(q, 16'h0006, "live request level");
		want = 1'b0;
		tick(2);
		chk(rst_n, 1'b1, "cpu reset idle");
		{bp_sel, bp_read, bp_addr} = {2'b11, LBGR_SOFT_RST_ADDR};
		tick(1);
		{bp_sel, bp_read} = 2'b00;
		chk(rst_n, 1'b0, "soft reset at once");
		wait_sig(3, 1'b1, 40);
		chk(16'(n), 16'(LBGR_SOFT_RST_CYC), "soft reset width");
		bp_rst_n = 1'b0;
		wait_sig(3, 1'b0, 40);
		chk(16'(n >= HW_DLY - 1 && n <= HW_DLY + 1), 16'h0001, "hw reset delay");
		bp_rst_n = 1'b1;
		wait_sig(3, 1'b1, 40);
		chk(16'(n >= HW_DLY - 1 && n <= HW_DLY + 1), 16'h0001, "hw release delay");
		for (int i = 0; i < 8; i++) begin
			q[0] = slow;
			tick(LBGR_SLOW_HALF);
			chk(slow, 16'(!q[0]), "slow clock toggle");
		end
		ce = 1'b0;
		q[0] = slow;
		tick(3);
		chk({slow, rst_n}, {q[0], 1'b1}, "clock enable freeze");
		ce = 1'b1;
		end_of_test();
	end
endmodule : local_bus_grant_relay_bench
`default_nettype wire
